// File: core/spiw_core.sv
// Serial port interrupt combiner, address-detect qualifier and wake logic.
// Assumes an APB master on pclk and receiver/transmitter status from neighbours.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Six sources merge into one serial interrupt request.
// - The request is a one-cycle active-low pulse.
// - Four flags gated by enables; transmit pair each own, receive pair shared.
// - Address detect raises interrupt without flag, only with detect mode on.
// - Pin wake raises interrupt without flag when wake and receive enables set.
// - Status flags have no write path; a control 1 write clears the transmit-empty flag.
// - In detect mode, receive interrupt only when top received bit is one.
// - Top bit is bit 8 with nine-bit select, else bit 7.
// - Without detect mode, receive interrupt each time the available flag sets.
// - Power-down pauses transfers; they resume when the clock returns.
// - Power-down leaves all serial registers unchanged.
// - All four enables set, sleep mode: falling pin edge wakes the processor.
// - Pin data during the start-up interval is ignored.
// - Wake interrupt needs global and serial enables too; else wake only.
// - Wake interrupt waits until the start-up interval has elapsed.
// - Idle with clock off: pin edge neither starts clock nor wakes.
// - Idle with clock on: idle edge starts clock; transfer wakes at end.
// - Idle clock on, receive enable clear: transfer end does not wake.
// - Sleep mode: pin edge starts clock and wakes processor.
// - Available flag sets with buffered word; clears on status access then data read.
module spiw_core (
  // APB
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Power mode and receive pin
  input  wire spiw_pkg::spiw_mode_t power_mode,
  input  wire logic             rx_pin,
  input  wire logic             xfer_busy,
  // Neighbour datapath status
  input  wire logic             tx_empty_evt,
  input  wire logic             tx_idle_lvl,
  input  wire logic             rx_word_valid,
  input  wire logic [8:0]       rx_word,
  input  wire logic             rx_overrun_evt,
  // To core
  output logic                  serial_irq_n,
  output logic                  wake_req,
  output logic                  clk_on_req,
  output logic                  port_clk_en,
  output logic                  rx_ignore
);
  import spiw_pkg::*;

  // ************************************************
  // Registers
  // ************************************************
  logic [7:0] ctrl1_r, ctrl1_nxt, ctrl2_r, ctrl2_nxt, baud_r, baud_nxt;
  logic [1:0] sysctl_r, sysctl_nxt;
  logic [8:0] rxd_r, rxd_nxt;
  logic       avail_r, avail_nxt, ovr_r, ovr_nxt, temp_r, temp_nxt;
  logic       stacc_r, stacc_nxt;
  logic       wr, rd;

  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    ctrl1_nxt  = ctrl1_r;
    ctrl2_nxt  = ctrl2_r;
    baud_nxt   = baud_r;
    sysctl_nxt = sysctl_r;
    rxd_nxt    = rxd_r;
    avail_nxt  = avail_r;
    ovr_nxt    = ovr_r;
    temp_nxt   = tx_empty_evt ? 1'b1 : temp_r;
    stacc_nxt  = stacc_r;
    // Status has no write path; a control 1 write clears transmit empty
    if (wr) begin
      case (paddr)
        SPIW_CTRL1_OFS:  ctrl1_nxt = pwdata[7:0];
        SPIW_CTRL2_OFS:  ctrl2_nxt = pwdata[7:0];
        SPIW_BAUD_OFS:   baud_nxt = pwdata[7:0];
        SPIW_SYSCTL_OFS: sysctl_nxt = pwdata[1:0];
        default: ;
      endcase
    end
    if (rd && paddr == SPIW_STATUS_OFS) begin
      stacc_nxt = 1'b1;
    end
    // Status access then data read clears
    if (rd && paddr == SPIW_RXDATA_OFS && stacc_r) begin
      avail_nxt = 1'b0;
      ovr_nxt   = 1'b0;
      stacc_nxt = 1'b0;
    end
    if (wr && paddr == SPIW_CTRL1_OFS) begin
      temp_nxt = 1'b0;
    end
    // Set wins over clear; pin data ignored during start-up
    if (rx_word_valid && !rx_ignore) begin
      avail_nxt = 1'b1;
      rxd_nxt   = rx_word;
    end
    if (rx_overrun_evt) begin
      ovr_nxt = 1'b1;
    end
    if (tx_empty_evt) begin
      temp_nxt = 1'b1;
    end
  end

  // Power-down has no reset path into these
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_r  <= SPIW_CTRL_RST;
      ctrl2_r  <= SPIW_CTRL_RST;
      baud_r   <= SPIW_BAUD_RST;
      sysctl_r <= 2'h0;
      rxd_r    <= 9'h000;
      avail_r  <= 1'b0;
      ovr_r    <= 1'b0;
      temp_r   <= 1'b1;
      stacc_r  <= 1'b0;
    end else begin
      ctrl1_r  <= ctrl1_nxt;
      ctrl2_r  <= ctrl2_nxt;
      baud_r   <= baud_nxt;
      sysctl_r <= sysctl_nxt;
      rxd_r    <= rxd_nxt;
      avail_r  <= avail_nxt;
      ovr_r    <= ovr_nxt;
      temp_r   <= temp_nxt;
      stacc_r  <= stacc_nxt;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      SPIW_STATUS_OFS: prdata = {28'h0, ovr_r, avail_r, tx_idle_lvl, temp_r};
      SPIW_CTRL1_OFS:  prdata = {24'h0, ctrl1_r};
      SPIW_CTRL2_OFS:  prdata = {24'h0, ctrl2_r};
      SPIW_BAUD_OFS:   prdata = {24'h0, baud_r};
      SPIW_RXDATA_OFS: prdata = {23'h0, rxd_r};
      SPIW_SYSCTL_OFS: prdata = {30'h0, sysctl_r};
      default:         prdata = 32'h0000_0000;
    endcase
  end

  // ************************************************
  // Enables
  // ************************************************
  logic rx_ie, wake_en, addr_detect_enable, all_wake_en, irq_en;
  assign rx_ie   = ctrl2_r[SPIW_C2_RX_IE];
  assign wake_en = ctrl2_r[SPIW_C2_WAKE];
  assign addr_detect_enable   = ctrl2_r[SPIW_C2_ADDR_DET];
  assign all_wake_en = wake_en & rx_ie & ctrl1_r[SPIW_C1_PORT_EN] & ctrl2_r[SPIW_C2_RX_EN];
  assign irq_en  = sysctl_r[SPIW_SC_GLOBAL_IE] & sysctl_r[SPIW_SC_SERIAL_IE];

  // ************************************************
  // Wake edge detector on the free-running pin side
  // ************************************************
  // Latch on the pin's own falling edge; cleared from pclk side
  logic edge_hit_r, edge_clr_r, edge_clr_nxt;
  always_ff @(negedge rx_pin or posedge edge_clr_r or negedge presetn) begin
    if (!presetn) begin
      edge_hit_r <= 1'b0;
    end else if (edge_clr_r) begin
      edge_hit_r <= 1'b0;
    end else begin
      edge_hit_r <= 1'b1;
    end
  end

  logic es1_r, es2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      es1_r <= 1'b0;
      es2_r <= 1'b0;
    end else begin
      es1_r <= edge_hit_r;
      es2_r <= es1_r;
    end
  end

  // ************************************************
  // Wake state machine
  // ************************************************
  typedef enum logic [1:0] {SPIW_W_IDLE, SPIW_W_START, SPIW_W_DONE} spiw_wst_t;
  spiw_wst_t  wst_r, wst_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic       wake_nxt, clkon_nxt, wirq_nxt, busy_d_r, busy_d_nxt;
  logic       wake_r, clkon_r, wirq_r;
  logic       xfer_end;

  assign xfer_end = busy_d_r & ~xfer_busy;

  always_comb begin
    wst_nxt      = wst_r;
    cnt_nxt      = cnt_r;
    wake_nxt     = 1'b0;
    clkon_nxt    = clkon_r;
    wirq_nxt     = 1'b0;
    edge_clr_nxt = 1'b0;
    busy_d_nxt   = xfer_busy;
    case (wst_r)
      SPIW_W_IDLE: begin
        if (es2_r) begin
          edge_clr_nxt = 1'b1;
          case (power_mode)
            SPIW_MODE_SLEEP: begin
              if (all_wake_en) begin
                wake_nxt  = 1'b1;
                clkon_nxt = 1'b1;
                cnt_nxt   = 8'(SPIW_STARTUP_CYCLES);
                wst_nxt   = SPIW_W_START;
              end
            end
            SPIW_MODE_IDLE_ON: begin
              if (all_wake_en && !xfer_busy) begin
                clkon_nxt = 1'b1;
              end
            end
            default: ; // Idle clock off ignores the edge
          endcase
        end
        // Transfer end wakes only with receive enable
        if (power_mode == SPIW_MODE_IDLE_ON && xfer_end && rx_ie && wake_en) begin
          wake_nxt = 1'b1;
          cnt_nxt  = 8'(SPIW_STARTUP_CYCLES);
          wst_nxt  = SPIW_W_START;
        end
        if (power_mode == SPIW_MODE_RUN) begin
          clkon_nxt = 1'b0;
        end
      end
      SPIW_W_START: begin
        // Interrupt withheld until start-up elapses
        if (cnt_r == 8'h00) begin
          wirq_nxt = irq_en;
          wst_nxt  = SPIW_W_DONE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      SPIW_W_DONE: begin
        clkon_nxt    = 1'b0;
        edge_clr_nxt = 1'b1;
        wst_nxt      = SPIW_W_IDLE;
      end
      default: wst_nxt = SPIW_W_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wst_r      <= SPIW_W_IDLE;
      cnt_r      <= 8'h00;
      wake_r     <= 1'b0;
      clkon_r    <= 1'b0;
      wirq_r     <= 1'b0;
      edge_clr_r <= 1'b0;
      busy_d_r   <= 1'b0;
    end else begin
      wst_r      <= wst_nxt;
      cnt_r      <= cnt_nxt;
      wake_r     <= wake_nxt;
      clkon_r    <= clkon_nxt;
      wirq_r     <= wirq_nxt;
      edge_clr_r <= edge_clr_nxt;
      busy_d_r   <= busy_d_nxt;
    end
  end

  assign wake_req   = wake_r;
  assign clk_on_req = clkon_r;
  assign rx_ignore  = (wst_r == SPIW_W_START);
  // Port clock stops in power-down; datapath pauses, no abort
  assign port_clk_en = (power_mode == SPIW_MODE_RUN) | clkon_r;

  // ************************************************
  // Interrupt combiner
  // ************************************************
  logic avail_d_r, avail_d_nxt, msb, rx_evt, addr_evt, src, irq_r, irq_nxt;
  logic tidle_d_r, tidle_d_nxt, temp_d_r, temp_d_nxt;
  assign msb = ctrl1_r[SPIW_C1_NINE_BIT] ? rxd_r[8] : rxd_r[7];
  assign rx_evt   = avail_r & ~avail_d_r;
  assign addr_evt = addr_detect_enable & rx_evt & msb;

  always_comb begin
    avail_d_nxt = avail_r;
    tidle_d_nxt = tx_idle_lvl;
    temp_d_nxt  = temp_r;
    // Pulse per new enabled condition
    src = (ctrl2_r[SPIW_C2_TEMPTY_IE] & temp_r & ~temp_d_r)
        | (ctrl2_r[SPIW_C2_TIDLE_IE] & tx_idle_lvl & ~tidle_d_r)
        | (rx_ie & rx_evt & ~addr_detect_enable)
        | (rx_ie & rx_overrun_evt)
        | (rx_ie & addr_evt)
        | wirq_r;
    irq_nxt = ~src;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avail_d_r <= 1'b0;
      tidle_d_r <= 1'b0;
      temp_d_r  <= 1'b0;
      irq_r     <= 1'b1;
    end else begin
      avail_d_r <= avail_d_nxt;
      tidle_d_r <= tidle_d_nxt;
      temp_d_r  <= temp_d_nxt;
      irq_r     <= irq_nxt;
    end
  end
  assign serial_irq_n = irq_r;

  // ************************************************
  // Checks
  // ************************************************
  AST_PULSE_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_idle_lvl && $past(tx_idle_lvl) && !(temp_r && !temp_d_r) && !rx_evt && !rx_overrun_evt && !wirq_r)
    |=> serial_irq_n) else $error("irq held low on a level");
  AST_ADDR_QUAL: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_evt && addr_detect_enable && !msb && !rx_overrun_evt && !wirq_r && !temp_r && !tx_idle_lvl) |=> serial_irq_n)
    else $error("addr mode irq on data word");
  AST_NO_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_evt && !addr_detect_enable && rx_ie) |=> !serial_irq_n) else $error("rx irq missed");
  AST_SLEEP_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (wst_r == SPIW_W_IDLE && es2_r && power_mode == SPIW_MODE_SLEEP && all_wake_en) |=> wake_req && clk_on_req)
    else $error("sleep wake missed");
  AST_IDLE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (wst_r == SPIW_W_IDLE && power_mode == SPIW_MODE_IDLE_OFF) |=> !wake_req) else $error("idle off woke");
  AST_WAIT_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (wst_r == SPIW_W_START && cnt_r != 8'h00) |=> !wirq_r) else $error("wake irq early");
  AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    wirq_r |-> $past(irq_en)) else $error("wake irq without enables");
  AST_IGNORE_RX: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_ignore && rx_word_valid) |=> $stable(rxd_r) && !$rose(avail_r))
    else $error("rx accepted in start-up");
  AST_RO_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == SPIW_STATUS_OFS && !rx_word_valid) |=> avail_r == $past(avail_r))
    else $error("status written");
endmodule

// File: include/spiw_pkg.sv
// Constants for the serial port interrupt and wake-up block.
// Assumes a 200 MHz APB clock and word-aligned 32-bit registers.
package spiw_pkg;
  // Register byte offsets
  localparam logic [11:0] SPIW_STATUS_OFS = 12'h000;
  localparam logic [11:0] SPIW_CTRL1_OFS  = 12'h004;
  localparam logic [11:0] SPIW_CTRL2_OFS  = 12'h008;
  localparam logic [11:0] SPIW_BAUD_OFS   = 12'h00c;
  localparam logic [11:0] SPIW_RXDATA_OFS = 12'h010;
  localparam logic [11:0] SPIW_SYSCTL_OFS = 12'h014;
  // Control 1 fields
  localparam int SPIW_C1_PORT_EN  = 7;
  localparam int SPIW_C1_NINE_BIT = 6;
  localparam int SPIW_C1_PARITY   = 5;
  // Control 2 fields
  localparam int SPIW_C2_TX_EN    = 7;
  localparam int SPIW_C2_RX_EN    = 6;
  localparam int SPIW_C2_ADDR_DET = 5;
  localparam int SPIW_C2_WAKE     = 3;
  localparam int SPIW_C2_RX_IE    = 2;
  localparam int SPIW_C2_TIDLE_IE = 1;
  localparam int SPIW_C2_TEMPTY_IE = 0;
  // Status fields
  localparam int SPIW_ST_OVERRUN  = 3;
  localparam int SPIW_ST_RX_AVAIL = 2;
  localparam int SPIW_ST_TX_IDLE  = 1;
  localparam int SPIW_ST_TX_EMPTY = 0;
  // System control fields
  localparam int SPIW_SC_GLOBAL_IE = 0;
  localparam int SPIW_SC_SERIAL_IE = 1;
  // Reset values
  localparam logic [7:0] SPIW_CTRL_RST = 8'h00;
  localparam logic [7:0] SPIW_BAUD_RST = 8'h00;
  // Timing
  localparam int SPIW_STARTUP_NS     = 1000;
  localparam int SPIW_CLK_NS         = 5;
  localparam int SPIW_STARTUP_CYCLES = (SPIW_STARTUP_NS + SPIW_CLK_NS - 1) / SPIW_CLK_NS;
  localparam int SPIW_PULSE_CYCLES   = 1;
  // Power modes
  typedef enum logic [1:0] {
    SPIW_MODE_RUN,
    SPIW_MODE_IDLE_OFF,
    SPIW_MODE_IDLE_ON,
    SPIW_MODE_SLEEP
  } spiw_mode_t;
endpackage

// File: test/spiw_host_model.sv
// Model of the core interrupt controller and power-mode control.
// Assumes spiw_core outputs on pclk; bench commands mode entry.
`timescale 1ns/1ps
module spiw_host_model (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // From block
  input  wire logic                 serial_irq_n,
  input  wire logic                 wake_req,
  input  wire logic                 clk_on_req,
  // From bench
  input  wire logic                 set_mode,
  input  wire spiw_pkg::spiw_mode_t new_mode,
  // To block and bench
  output spiw_pkg::spiw_mode_t      power_mode,
  output int                        irq_cnt,
  output int                        wake_cnt,
  output int                        clk_cnt
);
  import spiw_pkg::*;
  logic clk_on_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_mode <= SPIW_MODE_RUN;
      irq_cnt    <= 0;
      wake_cnt   <= 0;
      clk_cnt    <= 0;
      clk_on_q   <= 1'b0;
    end else begin
      // One count per low cycle, so a level shows as many
      if (!serial_irq_n) irq_cnt <= irq_cnt + 1;
      if (wake_req) wake_cnt <= wake_cnt + 1;
      clk_on_q <= clk_on_req;
      if (clk_on_req && !clk_on_q) clk_cnt <= clk_cnt + 1;
      if (set_mode) power_mode <= new_mode;
      else if (wake_req) power_mode <= SPIW_MODE_RUN;
    end
  end
endmodule

// File: test/testbench.sv
// Self-checking bench for the serial interrupt and wake block.
// Assumes spiw_core and the host model; APB master driven here.
`timescale 1ns/1ps
module testbench;
  import spiw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  spiw_mode_t  power_mode, new_mode;
  logic        rx_pin, xfer_busy, tx_empty_evt, tx_idle_lvl, rx_word_valid;
  logic        rx_overrun_evt, set_mode, serial_irq_n, wake_req, clk_on_req;
  logic        port_clk_en, rx_ignore;
  logic [8:0]  rx_word;
  int          irq_cnt, wake_cnt, clk_cnt, err_count, checks_done, i0, w0, c0;
  // {addr detect, nine bit, irq expected, word}
  logic [11:0] rxtab [6] = '{12'h600, 12'h2ff, 12'h87f, 12'ha80, 12'hcff, 12'hf00};

  spiw_core spiw_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .power_mode, .rx_pin, .xfer_busy,
    .tx_empty_evt, .tx_idle_lvl, .rx_word_valid, .rx_word, .rx_overrun_evt,
    .serial_irq_n, .wake_req, .clk_on_req, .port_clk_en, .rx_ignore);
  spiw_host_model spiw_host_model_i (.pclk, .presetn, .serial_irq_n, .wake_req,
    .clk_on_req, .set_mode, .new_mode, .power_mode, .irq_cnt, .wake_cnt, .clk_cnt);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    check("pready", pready, 1);
    check("pslverr", pslverr, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic irq_expect(string what, int n);
    repeat (6) @(posedge pclk);
    check(what, irq_cnt - i0, n);
    i0 = irq_cnt;
  endtask
  task automatic mode(spiw_mode_t m);
    set_mode <= 1'b1;
    new_mode <= m;
    @(posedge pclk);
    set_mode <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic rx_edge;
    w0 = wake_cnt;
    c0 = clk_cnt;
    i0 = irq_cnt;
    rx_pin <= 1'b0;
    repeat (12) @(posedge pclk);
    rx_pin <= 1'b1;
  endtask
  task automatic complete_run;
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    apb(0, SPIW_CTRL2_OFS, 0);
    check("ctrl2 reset", rd, {24'h0, SPIW_CTRL_RST});
    apb(0, SPIW_BAUD_OFS, 0);
    check("baud reset", rd, {24'h0, SPIW_BAUD_RST});
    apb(1, SPIW_BAUD_OFS, 32'h5a);
    apb(0, 12'h0f0, 0);
    check("unmapped", rd, 0);
    apb(1, SPIW_STATUS_OFS, 32'hf);
    apb(0, SPIW_STATUS_OFS, 0);
    check("status write", rd, 32'h1 << SPIW_ST_TX_EMPTY);
    apb(1, SPIW_STATUS_OFS, 0);
    apb(0, SPIW_STATUS_OFS, 0);
    check("status clear", rd, 32'h1 << SPIW_ST_TX_EMPTY);
  endtask
  task automatic t_tx;
    i0 = irq_cnt;
    tx_empty_evt <= 1'b1;
    @(posedge pclk);
    tx_empty_evt <= 1'b0;
    irq_expect("tx empty masked", 0);
    apb(1, SPIW_CTRL1_OFS, 0);
    apb(1, SPIW_CTRL2_OFS, 32'h1 << SPIW_C2_TEMPTY_IE);
    i0 = irq_cnt;
    tx_empty_evt <= 1'b1;
    @(posedge pclk);
    tx_empty_evt <= 1'b0;
    irq_expect("tx empty irq", 1);
    apb(1, SPIW_CTRL2_OFS, 32'h1 << SPIW_C2_TIDLE_IE);
    i0 = irq_cnt;
    tx_idle_lvl <= 1'b1;
    irq_expect("tx idle irq", 1);
    tx_idle_lvl <= 1'b0;
  endtask
  task automatic t_rx;
    foreach (rxtab[k]) begin
      apb(1, SPIW_CTRL1_OFS, {25'h0, rxtab[k][10], 6'h0}); // parity off
      apb(1, SPIW_CTRL2_OFS, {26'h0, rxtab[k][11], 5'h04});
      i0 = irq_cnt;
      rx_word <= rxtab[k][8:0];
      rx_word_valid <= 1'b1;
      @(posedge pclk);
      rx_word_valid <= 1'b0;
      irq_expect("rx irq", rxtab[k][9]);
      apb(0, SPIW_STATUS_OFS, 0);
      check("avail set", rd[SPIW_ST_RX_AVAIL], 1);
      apb(0, SPIW_RXDATA_OFS, 0);
      check("rx data", rd[8:0], rxtab[k][8:0]);
      apb(0, SPIW_STATUS_OFS, 0);
      check("avail clear", rd[SPIW_ST_RX_AVAIL], 0);
    end
    apb(1, SPIW_CTRL2_OFS, 32'h04);
    i0 = irq_cnt;
    rx_overrun_evt <= 1'b1;
    @(posedge pclk);
    rx_overrun_evt <= 1'b0;
    irq_expect("overrun irq", 1);
    apb(0, SPIW_STATUS_OFS, 0);
    apb(0, SPIW_RXDATA_OFS, 0);
  endtask
  task automatic t_sleep(logic [31:0] sc, int exp_irq);
    apb(1, SPIW_CTRL1_OFS, 32'h80);
    apb(1, SPIW_CTRL2_OFS, 32'h4c);
    apb(1, SPIW_SYSCTL_OFS, sc);
    xfer_busy <= 1'b0;
    mode(SPIW_MODE_SLEEP);
    check("port clock off", port_clk_en, 0);
    rx_edge;
    check("sleep wake", wake_cnt - w0, 1);
    check("sleep clock on", clk_cnt != c0, 1);
    check("ignore window", rx_ignore, 1);
    rx_word <= 9'h155;
    rx_word_valid <= 1'b1;
    @(posedge pclk);
    rx_word_valid <= 1'b0;
    repeat (100) @(posedge pclk);
    check("early irq", irq_cnt - i0, 0);
    repeat (150) @(posedge pclk);
    check("wake irq", irq_cnt - i0, exp_irq);
    apb(0, SPIW_STATUS_OFS, 0);
    check("ignored word", rd[SPIW_ST_RX_AVAIL], 0);
    apb(0, SPIW_CTRL2_OFS, 0);
    check("ctrl2 kept", rd, 32'h4c);
    apb(0, SPIW_BAUD_OFS, 0);
    check("baud kept", rd, 32'h5a);
  endtask
  task automatic t_idle;
    mode(SPIW_MODE_IDLE_OFF);
    rx_edge;
    repeat (20) @(posedge pclk);
    check("idle off wake", wake_cnt - w0, 0);
    check("idle off clock", clk_cnt - c0, 0);
    mode(SPIW_MODE_RUN);
    mode(SPIW_MODE_IDLE_ON);
    rx_edge;
    check("idle on clock", clk_cnt - c0, 1);
    check("idle on no wake", wake_cnt - w0, 0);
    for (int k = 0; k < 2; k++) begin
      mode(SPIW_MODE_IDLE_ON);
      w0 = wake_cnt;
      xfer_busy <= 1'b1;
      repeat (20) @(posedge pclk);
      xfer_busy <= 1'b0;
      repeat (12) @(posedge pclk);
      check("transfer end wake", wake_cnt - w0, 1 - k);
      apb(1, SPIW_CTRL2_OFS, 32'h48);
      repeat (SPIW_STARTUP_CYCLES + 10) @(posedge pclk);
    end
  endtask

  // ****************************************
  // Clock, sequence and watchdog
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, set_mode, xfer_busy} = '0;
    {tx_empty_evt, tx_idle_lvl, rx_word_valid, rx_word, rx_overrun_evt} = '0;
    new_mode = SPIW_MODE_RUN;
    rx_pin = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_tx;
    t_rx;
    t_sleep(32'h3, 1);
    t_sleep(32'h0, 0);
    t_idle;
    complete_run;
  end
  initial begin
    #200000;
    err_count++;
    complete_run;
  end
endmodule
